// ---- verilog/ws_state_swap_cfg.svh ----
// Offsets, masks, reset defaults and limits of the world-switch swap engine
`ifndef WS_STATE_SWAP_CFG_SVH
`define WS_STATE_SWAP_CFG_SVH
`define WS_GUEST_BASE 12'h000
`define WS_HOST_BASE 12'h400
`define WS_LAST_OFF 12'h268
`define WS_OFF_STEP 12'h008
`define WS_OFF_PRIV 12'h0C8
`define WS_OFF_PAT 12'h268
`define WS_OFF_DR7 12'h160
`define WS_OFF_DR6 12'h168
`define WS_BE_ALL 8'hFF
`define WS_BE_GUEST_PRIV 8'h0C
`define WS_BE_HOST_PRIV 8'h08
`define WS_DEF_DR7 64'h0000_0000_0000_0400
`define WS_DEF_DR6 64'h0000_0000_FFFF_0FF0
`define WS_DEF_OTHER 64'h0000_0000_0000_0000
`endif

// ---- verilog/ws_pkg.sv ----
// Types of the world-switch swap engine
package ws_pkg;
   typedef enum logic [2:0] {
      CAT_RSV = 3'h0,
      CAT_A = 3'h1,
      CAT_B = 3'h2,
      CAT_C = 3'h3,
      CAT_G = 3'h4
   } ws_cat_type;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_PICK = 6'h02,
      ST_SAVE = 6'h04,
      ST_LOAD = 6'h08,
      ST_ADV = 6'h10,
      ST_DONE = 6'h20
   } ws_fsm_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [63:0] addr;
      logic [7:0] be;
      logic [63:0] wdata;
   } ws_mem_type;

   typedef struct packed {
      logic [8:0] idx;
      logic we;
      logic [7:0] be;
      logic [63:0] wdata;
   } ws_reg_type;

   typedef struct packed {
      ws_fsm_type state;
      ws_cat_type cat;
      logic exitDir;
      logic toHost;
      logic saveDone;
      logic [11:0] off;
      logic [51:0] guestPg;
      logic [51:0] hostPg;
      ws_mem_type mem;
      ws_reg_type rf;
      logic busy;
      logic done;
   } ws_state_type;
endpackage : ws_pkg

// ---- verilog/ws_state_swap.sv ----
// World-switch state swap engine for encrypted-state guests
// Function
// - With encrypted guests enabled the guest save structure starts at byte zero of its page.
// - On entry, first-category fields save the host value to the host area, then load the guest.
// - On exit, first-category fields save the guest value, then restore the host value.
// - Second-category fields load the guest on entry, and on exit save guest then reload host.
// - Third-category fields load the guest on entry, and on exit save guest then reset the host.
// - The host save area has the guest layout but is based at byte 0x400 of the host page.
// - The privilege-level byte at 0xCB is swapped for guest and host; the guest side also carries byte 0xCA.
// - The page-attribute-table field at 0x268 is swapped for the guest only.
`include "ws_state_swap_cfg.svh"

module ws_state_swap
   import ws_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic esEnable,
   input wire logic startEntry,
   input wire logic startExit,
   input wire logic [51:0] guestPagePtr,
   input wire logic [51:0] hostPagePtr,
   output ws_mem_type memOut,
   input wire logic memAck,
   input wire logic [63:0] memRdata,
   output ws_reg_type regOut,
   input wire logic [63:0] regRdata,
   output logic busy,
   output logic done
);

   ws_state_type q;
   ws_state_type d;

   // Category fixed by offset alone; reserved holes give CAT_RSV
   function automatic ws_cat_type catOf(input logic [11:0] off);
      ws_cat_type c;
      c = CAT_RSV;
      if (off < 12'h0A0) begin
         unique case (off[7:4])
            4'h4, 4'h5, 4'h7, 4'h9: c = CAT_B;
            default: c = CAT_A;
         endcase
      end else if (off <= 12'h0C0) c = CAT_B;
      else if (off == `WS_OFF_PRIV || off == 12'h0D0) c = CAT_A;
      else if (off == 12'h140) c = CAT_B;
      else if (off >= 12'h148 && off <= 12'h158) c = CAT_A;
      else if (off == `WS_OFF_DR7 || off == `WS_OFF_DR6 || off == 12'h240) c = CAT_C;
      else if (off == 12'h170 || off == 12'h178) c = CAT_A;
      else if (off >= 12'h180 && off <= 12'h1B8) c = CAT_B;
      else if (off >= 12'h1D8 && off <= 12'h1F8) c = CAT_A;
      else if (off >= 12'h200 && off <= 12'h238) c = CAT_B;
      else if (off == `WS_OFF_PAT) c = CAT_G;
      return c;
   endfunction : catOf

   // Host side of the privilege qword carries only the current-level byte
   function automatic logic [7:0] beOf(input logic [11:0] off, input logic host);
      logic [7:0] be;
      be = `WS_BE_ALL;
      if (off == `WS_OFF_PRIV) be = host ? `WS_BE_HOST_PRIV : `WS_BE_GUEST_PRIV;
      return be;
   endfunction : beOf

   function automatic logic [63:0] addrOf(input logic [51:0] pg, input logic [11:0] off,
                                          input logic host);
      logic [11:0] base;
      base = host ? `WS_HOST_BASE : `WS_GUEST_BASE;
      return {pg, 12'(base + off)};
   endfunction : addrOf

   function automatic logic [63:0] defaultOf(input logic [11:0] off);
      logic [63:0] v;
      v = `WS_DEF_OTHER;
      if (off == `WS_OFF_DR7) v = `WS_DEF_DR7;
      else if (off == `WS_OFF_DR6) v = `WS_DEF_DR6;
      return v;
   endfunction : defaultOf

   always_comb begin
      d = q;
      d.rf.we = 1'b0;
      d.done = 1'b0;
      unique case (q.state)
         ST_IDLE: begin
            // Only encrypted-state switches are handled here
            if ((startEntry || startExit) && esEnable) begin
               d.exitDir = !startEntry;
               d.guestPg = guestPagePtr;
               d.hostPg = hostPagePtr;
               d.off = `WS_GUEST_BASE;
               d.busy = 1'b1;
               d.state = ST_PICK;
            end
         end
         ST_PICK: begin
            d.cat = catOf(q.off);
            d.rf.idx = q.off[11:3];
            d.saveDone = 1'b0;
            if (catOf(q.off) == CAT_RSV) begin
               d.state = ST_ADV;
            end else if (q.exitDir || catOf(q.off) == CAT_A) begin
               d.toHost = !q.exitDir;
               d.state = ST_SAVE;
            end else begin
               d.toHost = 1'b0;
               d.state = ST_LOAD;
            end
         end
         ST_SAVE: begin
            if (!q.mem.req) begin
               d.mem.req = 1'b1;
               d.mem.we = 1'b1;
               d.mem.addr = addrOf(q.toHost ? q.hostPg : q.guestPg, q.off, q.toHost);
               d.mem.be = beOf(q.off, q.toHost);
               d.mem.wdata = regRdata;
            end else if (memAck) begin
               d.mem.req = 1'b0;
               d.mem.we = 1'b0;
               d.saveDone = 1'b1;
               if (!q.exitDir) begin
                  d.toHost = 1'b0;
                  d.state = ST_LOAD;
               end else if (q.cat == CAT_A || q.cat == CAT_B) begin
                  d.toHost = 1'b1;
                  d.state = ST_LOAD;
               end else if (q.cat == CAT_C) begin
                  d.rf.we = 1'b1;
                  d.rf.be = `WS_BE_ALL;
                  d.rf.wdata = defaultOf(q.off);
                  d.state = ST_ADV;
               end else begin
                  d.state = ST_ADV;
               end
            end
         end
         ST_LOAD: begin
            if (!q.mem.req) begin
               d.mem.req = 1'b1;
               d.mem.we = 1'b0;
               d.mem.addr = addrOf(q.toHost ? q.hostPg : q.guestPg, q.off, q.toHost);
               d.mem.be = beOf(q.off, q.toHost);
            end else if (memAck) begin
               d.mem.req = 1'b0;
               d.rf.we = 1'b1;
               d.rf.be = beOf(q.off, q.toHost);
               d.rf.wdata = memRdata;
               d.state = ST_ADV;
            end
         end
         ST_ADV: begin
            if (q.off == `WS_LAST_OFF) d.state = ST_DONE;
            else begin
               d.off = 12'(q.off + `WS_OFF_STEP);
               d.state = ST_PICK;
            end
         end
         ST_DONE: begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) q <= '{state: ST_IDLE, cat: CAT_RSV, default: '0};
      else q <= d;
   end

   assign memOut = q.mem;
   assign regOut = q.rf;
   assign busy = q.busy;
   assign done = q.done;

   // Guest accesses stay in the low quarter of the guest page
   a_guest_base: assert property (@(posedge clk) disable iff (!rstn)
      (q.mem.req && !q.toHost) |->
         (q.mem.addr[63:12] == q.guestPg && q.mem.addr[11:0] < `WS_HOST_BASE))
      else $error("guest access outside guest structure");

   a_host_base: assert property (@(posedge clk) disable iff (!rstn)
      (q.mem.req && q.toHost) |->
         (q.mem.addr[63:12] == q.hostPg && q.mem.addr[11:0] == 12'(q.off + `WS_HOST_BASE)))
      else $error("host access not at host base plus offset");

   a_entry_order: assert property (@(posedge clk) disable iff (!rstn)
      (q.rf.we && !q.exitDir && q.cat == CAT_A) |-> (q.saveDone && $past(memAck)))
      else $error("guest load before host save");

   a_exit_restore: assert property (@(posedge clk) disable iff (!rstn)
      (q.rf.we && q.exitDir && q.cat == CAT_A) |-> (q.saveDone && q.toHost))
      else $error("host restore without guest save");

   a_nosave_host: assert property (@(posedge clk) disable iff (!rstn)
      (q.mem.req && q.mem.we && q.toHost) |-> (!q.exitDir && q.cat == CAT_A))
      else $error("host save for wrong category");

   a_reset_default: assert property (@(posedge clk) disable iff (!rstn)
      (q.rf.we && q.exitDir && q.cat == CAT_C) |->
         (q.saveDone && q.rf.wdata == defaultOf(q.off) && $past(q.state) == ST_SAVE))
      else $error("third-category host value not reset default");

   a_priv_byte: assert property (@(posedge clk) disable iff (!rstn)
      (q.mem.req && q.off == `WS_OFF_PRIV) |->
         (q.mem.be == (q.toHost ? `WS_BE_HOST_PRIV : `WS_BE_GUEST_PRIV)))
      else $error("privilege byte mask wrong");

   a_pat_guest: assert property (@(posedge clk) disable iff (!rstn)
      (q.off == `WS_OFF_PAT && q.state != ST_IDLE) |-> !(q.mem.req && q.toHost))
      else $error("page attribute field used in host area");

   a_no_reserved: assert property (@(posedge clk) disable iff (!rstn)
      (q.mem.req || q.rf.we) |-> (catOf(q.off) != CAT_RSV && q.cat == catOf(q.off)))
      else $error("reserved range accessed");

   // Second-category exit reloads the host copy only after the guest save
   a_exit_reload: assert property (@(posedge clk) disable iff (!rstn)
      (q.rf.we && q.exitDir && q.cat == CAT_B) |-> (q.saveDone && q.toHost))
      else $error("second-category host reload without guest save");

endmodule : ws_state_swap

// ---- testbench/ws_state_swap_tb.sv ----
// Self-checking bench for the world-switch state swap engine
`include "ws_state_swap_cfg.svh"
module ws_state_swap_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rstn = 0, esEnable = 0, startEntry = 0, startExit = 0, memAck = 0;
   logic [51:0] guestPagePtr = '0, hostPagePtr = '0;
   logic [63:0] memRdata = '0, regRdata;
   logic [54:0] regSeed = '0;
   ws_pkg::ws_mem_type memOut;
   ws_pkg::ws_reg_type regOut;
   logic busy, done;
   logic [137:0] expQ[$];
   int num_errors = 0, checks_done = 0, cnt = 0;
   ws_state_swap dut (.clk(clk), .rstn(rstn), .esEnable(esEnable), .startEntry(startEntry),
      .startExit(startExit), .guestPagePtr(guestPagePtr), .hostPagePtr(hostPagePtr),
      .memOut(memOut), .memAck(memAck), .memRdata(memRdata), .regOut(regOut),
      .regRdata(regRdata), .busy(busy), .done(done));
   // Live register value tracks the index, so a wrong index shows in the data
   assign regRdata = {regSeed, regOut.idx};
   initial forever #50 clk = ~clk;
   function automatic logic [63:0] pat(logic [63:0] a);
      return {a[31:0] ^ 32'h5A5A_5A5A, ~a[31:0]};
   endfunction : pat
   function automatic int cat(logic [11:0] o);
      if (o < 12'h040 || (o >= 12'h060 && o < 12'h070) || (o >= 12'h080 && o < 12'h090)) return 1;
      if (o == 12'h0C8 || o == 12'h0D0 || (o >= 12'h148 && o <= 12'h158)) return 1;
      if (o == 12'h170 || o == 12'h178 || (o >= 12'h1D8 && o < 12'h200)) return 1;
      if (o == 12'h160 || o == 12'h168 || o == 12'h240) return 3;
      if (o == 12'h268) return 4;
      if ((o >= 12'h0D8 && o < 12'h140) || (o >= 12'h1C0 && o < 12'h1D8) || o >= 12'h248) return 0;
      return 2;
   endfunction : cat
   task automatic check(logic [137:0] seen, logic [137:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic push(logic [1:0] k, logic [63:0] a, logic [7:0] b, logic [63:0] d);
      expQ.push_back({k, a, b, d});
   endtask : push
   task automatic build(bit ext);
      logic [63:0] g, h, rv, dv;
      logic [7:0] gb, hb;
      int c;
      for (int o = 0; o <= 12'h268; o += 8) begin
         c = cat(o[11:0]);
         g = {guestPagePtr, 12'h000} + o;
         h = {hostPagePtr, 12'h400} + o;
         rv = {regSeed, o[11:3]};
         gb = (o == 12'h0C8) ? 8'h0C : 8'hFF;
         hb = (o == 12'h0C8) ? 8'h08 : 8'hFF;
         dv = (o == 12'h160) ? `WS_DEF_DR7 : (o == 12'h168) ? `WS_DEF_DR6 : `WS_DEF_OTHER;
         if (!ext) begin
            if (c == 1) push(2'h1, h, hb, rv);
            if (c != 0) begin
               push(2'h2, g, gb, 64'h0);
               push(2'h3, o[11:3], gb, pat(g));
            end
         end else if (c != 0) begin
            push(2'h1, g, gb, rv);
            if (c == 1 || c == 2) begin
               push(2'h2, h, hb, 64'h0);
               push(2'h3, o[11:3], hb, pat(h));
            end
            if (c == 3) push(2'h3, o[11:3], 8'hFF, dv);
         end
      end
   endtask : build
   task automatic take(logic [137:0] v);
      if (expQ.size() == 0) check(v, '1);
      else check(v, expQ.pop_front());
   endtask : take
   always @(posedge clk) begin
      if (rstn && memOut.req && memAck)
         take({memOut.we ? 2'h1 : 2'h2, memOut.addr, memOut.be,
               memOut.we ? memOut.wdata : 64'h0});
      if (rstn && regOut.we) take({2'h3, 55'h0, regOut.idx, regOut.be, regOut.wdata});
   end
   // Random latency of 1 to 3 cycles; data churns only while no request waits for an acknowledge
   always @(negedge clk) begin
      if (memAck || !memOut.req) begin
         memAck = 0;
         cnt = 0;
         memRdata = {$urandom, $urandom};
      end else begin
         if (cnt == 0) cnt = $urandom_range(3, 1);
         cnt--;
         if (cnt == 0) begin
            memAck = 1;
            memRdata = pat(memOut.addr);
         end
      end
   end
   task automatic run(bit ent, bit ext, bit en);
      logic [63:0] r;
      int n;
      @(negedge clk);
      r = {$urandom, $urandom};
      guestPagePtr = r[51:0];
      r = {$urandom, $urandom};
      hostPagePtr = r[51:0];
      regSeed = r[54:0];
      esEnable = en;
      startEntry = ent;
      startExit = ext;
      if (en) build(!ent);
      @(negedge clk);
      startEntry = 0;
      startExit = 0;
      check(busy === en, 1);
      // A start while busy must not restart the sweep
      @(negedge clk);
      startExit = 1;
      @(negedge clk);
      startExit = 0;
      n = 0;
      while (done !== 1'b1 && n < (en ? 3000 : 40)) begin
         @(negedge clk);
         n++;
      end
      check(done === en, 1);
      check(expQ.size(), 0);
      expQ.delete();
   endtask : run
   task automatic results();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : results
   initial begin
      void'($urandom(39));
      repeat (3) @(negedge clk);
      rstn = 1;
      // Idle after reset: no access and no register write
      @(negedge clk);
      check({busy, done, memOut.req, regOut.we}, 0);
      run(1, 0, 1);
      run(0, 1, 1);
      run(1, 1, 1);
      run(0, 1, 0);
      run(1, 0, 1);
      run(0, 1, 1);
      results();
   end
   initial begin
      #3_000_000;
      num_errors++;
      results();
   end
endmodule : ws_state_swap_tb
